// [src/fpp_pkg.sv]
/*
 * shared constants and types for the flash program/erase guard and ram overlay.
 * assumes an 8-bit register port and a single system clock.
 */
package fpp_pkg;

    // ==========================================================
    // register map
    localparam logic [2:0] FPP_ADR_CTRL = 3'h0;
    localparam logic [2:0] FPP_ADR_KEY = 3'h1;
    localparam logic [2:0] FPP_ADR_OVL = 3'h2;
    localparam logic [2:0] FPP_ADR_DLTGT = 3'h3;
    localparam logic [2:0] FPP_ADR_PECMD = 3'h4;
    localparam logic [2:0] FPP_ADR_RESULT = 3'h5;

    // ==========================================================
    // field positions
    localparam int FPP_CTRL_DLREQ = 0;
    localparam int FPP_CTRL_DLDONE = 1;
    localparam int FPP_CTRL_BUSY = 2;
    localparam int FPP_CTRL_ERR = 7;
    localparam int FPP_OVL_EN = 3;
    localparam int FPP_PECMD_PROG = 0;
    localparam int FPP_PECMD_ERASE = 1;

    // ==========================================================
    // key values and reset values
    localparam logic [7:0] FPP_KEY_DL = 8'ha5;
    localparam logic [7:0] FPP_KEY_PE = 8'h5a;
    localparam logic [7:0] FPP_RST_BYTE = 8'h00;
    localparam logic [7:0] FPP_RST_DLTGT = 8'h00;

    // ==========================================================
    // result codes for a program/erase attempt
    localparam logic [7:0] FPP_RSLT_OK = 8'h00;
    localparam logic [7:0] FPP_RSLT_KEY = 8'h01;
    localparam logic [7:0] FPP_RSLT_NODL = 8'h02;
    localparam logic [7:0] FPP_RSLT_OVL = 8'h03;
    localparam logic [7:0] FPP_RSLT_ERRP = 8'h04;
    localparam logic [7:0] FPP_RSLT_ABORT = 8'h05;

    // ==========================================================
    // overlay geometry
    localparam int FPP_OFS_W = 6;
    localparam int FPP_DW = 8;
    localparam int FPP_DEPTH = 64;

    // minimum reset hold after error protection, in microseconds
    localparam int FPP_RST_HOLD_US = 100;
    localparam int FPP_CLK_MHZ = 100;
    localparam int FPP_RST_HOLD_CYC = FPP_RST_HOLD_US * FPP_CLK_MHZ;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } fpp_reg_req_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [2:0] blk;
        logic [FPP_OFS_W-1:0] ofs;
        logic [FPP_DW-1:0] wdata;
    } fpp_flash_req_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [FPP_OFS_W-1:0] ofs;
        logic [FPP_DW-1:0] wdata;
    } fpp_ram_req_t;

    typedef struct packed {
        logic irq;
        logic nmi;
        logic sleep;
        logic alt_master;
    } fpp_err_evt_t;

    typedef enum logic [1:0] {
        FPP_ST_IDLE = 2'b00,
        FPP_ST_DL = 2'b01,
        FPP_ST_PE = 2'b11,
        FPP_ST_ERR = 2'b10
    } fpp_state_t;

endpackage : fpp_pkg

// [src/fpp_ovl_ram.sv]
/*
 * single-port storage of the overlay ram with registered read data.
 * assumes the caller arbitrates between its users.
 */
`timescale 1ns/1ns
module fpp_ovl_ram
    import fpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic en,
    input wire logic we,
    input wire logic [FPP_OFS_W-1:0] addr,
    input wire logic [FPP_DW-1:0] wdata,
    output logic [FPP_DW-1:0] rdata_q
);

    logic [FPP_DW-1:0] mem [FPP_DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (en && we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (en && !we)
        begin
            rdata_q <= mem[addr];
        end
    end

endmodule : fpp_ovl_ram

// [src/fpp_guard.sv]
/*
 * flash program/erase protection (hardware, software, error) and the
 * ram overlay that stands in for one user flash block.
 * assumes all event inputs come from logic on clk_sys, and that the
 * flash macro answers a started operation with a one-cycle done pulse.
 */
// Strobed register access and the placing of the registers were left to the implementer.
// How it works
// RL1: any reset clears registers, enters protection
// RL2: protected: download allowed, program/erase reports error
// RL3: reset mid-operation: software erases then reprograms
// RL4: download bit zero refuses download
// RL5: wrong key blocks download and program/erase
// RL6: key A5 for download, 5A for program/erase
// RL7: writing download bit with key starts download
// RL8: overlay enable puts device into protection
// RL9: overlay enable protects all blocks, refuses download
// RL10: error sets flag, aborts, enters error protection
// RL11: interrupt or nmi during operation is error
// RL12: flash read during operation is error
// RL13: sleep during operation is error
// RL14: other bus master during operation is error
// RL15: only reset leaves error protection, hold long
// RL16: overlaid block and ram reach same storage
// RL17: three-bit select picks one of eight blocks
// RL18: overlay works in user and user program mode
// RL19: download target overlapping tuned data, save first
// RL20: software clears overlay before real programming
// RL21: error flag survives software writes until reset
`timescale 1ns/1ns
module fpp_guard
    import fpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire fpp_reg_req_t reg_req,
    output logic [7:0] rd_data_q,
    input wire fpp_flash_req_t flash_req,
    input wire fpp_ram_req_t ram_req,
    input wire fpp_err_evt_t err_evt,
    input wire logic user_mode,
    input wire logic dl_done,
    input wire logic pe_done,
    output logic dl_start_q,
    output logic pe_prog_q,
    output logic pe_erase_q,
    output logic pe_abort_q,
    output logic err_flag_q,
    output logic ovl_hit_q,
    output logic ovl_rvalid_q,
    output logic [FPP_DW-1:0] ovl_rdata
);

    // ==========================================================
    // helpers
    function automatic logic key_is(input logic [7:0] key, input logic [7:0] want);
        key_is = (key == want);
    endfunction : key_is

    function automatic logic wr_at(input fpp_reg_req_t r, input logic [2:0] a);
        wr_at = r.we && (r.addr == a);
    endfunction : wr_at

    // ==========================================================
    // registers
    logic dl_req_bit_q;
    logic dl_done_bit_q;
    logic [7:0] key_q;
    logic ovl_en_q;
    logic [2:0] ovl_sel_q;
    logic [7:0] dl_tgt_q;
    logic [7:0] result_q;
    fpp_state_t state_q;
    fpp_state_t state_d;

    logic dl_go;
    logic pe_go;
    logic pe_cmd_wr;
    logic any_err;
    logic flash_read_hit;

    // RL8 RL9 overlay or error flag blocks download and program/erase
    logic sw_block;
    assign sw_block = ovl_en_q || err_flag_q;

    // RL4 RL5 RL7 download needs bit, key A5, no overlay
    assign dl_go = wr_at(reg_req, FPP_ADR_CTRL) && reg_req.wdata[FPP_CTRL_DLREQ]
        && key_is(key_q, FPP_KEY_DL) && !sw_block && state_q == FPP_ST_IDLE;

    assign pe_cmd_wr = wr_at(reg_req, FPP_ADR_PECMD)
        && (reg_req.wdata[FPP_PECMD_PROG] || reg_req.wdata[FPP_PECMD_ERASE]);

    // RL2 RL5 RL6 program/erase needs key 5A and a finished download
    assign pe_go = pe_cmd_wr && key_is(key_q, FPP_KEY_PE) && dl_done_bit_q
        && !sw_block && state_q == FPP_ST_IDLE;

    // RL11 RL12 RL13 RL14 illegal events while operating
    assign flash_read_hit = flash_req.req && !flash_req.we;
    assign any_err = state_q == FPP_ST_PE && (err_evt.irq || err_evt.nmi
        || err_evt.sleep || err_evt.alt_master || flash_read_hit);

    // ==========================================================
    // sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            FPP_ST_IDLE:
            begin
                if (dl_go)
                    state_d = FPP_ST_DL;
                else if (pe_go)
                    state_d = FPP_ST_PE;
            end
            FPP_ST_DL:
            begin
                if (dl_done)
                    state_d = FPP_ST_IDLE;
            end
            FPP_ST_PE:
            begin
                // RL10 abort into error protection
                if (any_err)
                    state_d = FPP_ST_ERR;
                else if (pe_done)
                    state_d = FPP_ST_IDLE;
            end
            // RL15 only reset leaves this state
            FPP_ST_ERR:
            begin
                state_d = FPP_ST_ERR;
            end
            default:
            begin
                state_d = FPP_ST_IDLE;
            end
        endcase
    end

    // RL1 reset returns to protected idle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_q <= FPP_ST_IDLE;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // software registers
    // RL1 RL6 key cleared by reset, software rewrites it
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            key_q <= FPP_RST_BYTE;
        else if (wr_at(reg_req, FPP_ADR_KEY))
            key_q <= reg_req.wdata;
    end

    // RL17 three-bit block select
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ovl_en_q <= 1'b0;
            ovl_sel_q <= 3'h0;
        end
        else if (wr_at(reg_req, FPP_ADR_OVL))
        begin
            ovl_en_q <= reg_req.wdata[FPP_OVL_EN];
            ovl_sel_q <= reg_req.wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            dl_tgt_q <= FPP_RST_DLTGT;
        else if (wr_at(reg_req, FPP_ADR_DLTGT))
            dl_tgt_q <= reg_req.wdata;
    end

    // download bit reads back high while a download runs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            dl_req_bit_q <= 1'b0;
        else if (dl_go)
            dl_req_bit_q <= 1'b1;
        else if (state_q == FPP_ST_DL && dl_done)
            dl_req_bit_q <= 1'b0;
    end

    // a program/erase is only legal once routines are downloaded
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            dl_done_bit_q <= 1'b0;
        else if (state_q == FPP_ST_DL && dl_done)
            dl_done_bit_q <= 1'b1;
    end

    // ==========================================================
    // result of each program/erase attempt made while idle or in error protection
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            result_q <= FPP_RSLT_OK;
        else if (any_err)
            result_q <= FPP_RSLT_ABORT;
        else if (pe_cmd_wr && (state_q == FPP_ST_IDLE || err_flag_q))
        begin
            // RL2 refused attempts report an error code
            if (err_flag_q)
                result_q <= FPP_RSLT_ERRP;
            else if (ovl_en_q)
                result_q <= FPP_RSLT_OVL;
            else if (!key_is(key_q, FPP_KEY_PE))
                result_q <= FPP_RSLT_KEY;
            else if (!dl_done_bit_q)
                result_q <= FPP_RSLT_NODL;
            else
                result_q <= FPP_RSLT_OK;
        end
    end

    // ==========================================================
    // error flag
    // RL10 RL21 sticky, no software clear path
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            err_flag_q <= 1'b0;
        else if (any_err)
            err_flag_q <= 1'b1;
    end

    // ==========================================================
    // flash macro controls
    // RL7 one-cycle download start
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            dl_start_q <= 1'b0;
        else
            dl_start_q <= dl_go;
    end

    // RL10 enables drop in the cycle after the error
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pe_prog_q <= 1'b0;
            pe_erase_q <= 1'b0;
        end
        else if (pe_go)
        begin
            pe_prog_q <= reg_req.wdata[FPP_PECMD_PROG];
            pe_erase_q <= reg_req.wdata[FPP_PECMD_ERASE] && !reg_req.wdata[FPP_PECMD_PROG];
        end
        else if (any_err || pe_done)
        begin
            pe_prog_q <= 1'b0;
            pe_erase_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            pe_abort_q <= 1'b0;
        else
            pe_abort_q <= any_err;
    end

    // ==========================================================
    // overlay
    // RL16 RL18 flash window of selected block maps to ram
    logic flash_hit;
    logic mem_en;
    logic mem_we;
    logic [FPP_OFS_W-1:0] mem_addr;
    logic [FPP_DW-1:0] mem_wdata;

    // RL17 exact match on the select field
    assign flash_hit = ovl_en_q && user_mode && flash_req.req && flash_req.blk == ovl_sel_q;

    // ram port wins; a colliding flash access is dropped and shows no hit
    always_comb
    begin
        mem_en = 1'b0;
        mem_we = 1'b0;
        mem_addr = '0;
        mem_wdata = '0;
        if (ram_req.req)
        begin
            mem_en = 1'b1;
            mem_we = ram_req.we;
            mem_addr = ram_req.ofs;
            mem_wdata = ram_req.wdata;
        end
        else if (flash_hit)
        begin
            mem_en = 1'b1;
            mem_we = flash_req.we;
            mem_addr = flash_req.ofs;
            mem_wdata = flash_req.wdata;
        end
    end

    fpp_ovl_ram u_ram (
        .clk_sys(clk_sys),
        .en(mem_en),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata_q(ovl_rdata)
    );

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ovl_hit_q <= 1'b0;
            ovl_rvalid_q <= 1'b0;
        end
        else
        begin
            ovl_hit_q <= flash_hit && !ram_req.req;
            ovl_rvalid_q <= mem_en && !mem_we;
        end
    end

    // ==========================================================
    // register read, data in the following cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rd_data_q <= FPP_RST_BYTE;
        else if (reg_req.re)
        begin
            case (reg_req.addr)
                FPP_ADR_CTRL:
                    rd_data_q <= {err_flag_q, 4'h0, state_q != FPP_ST_IDLE,
                        dl_done_bit_q, dl_req_bit_q};
                FPP_ADR_KEY:
                    rd_data_q <= key_q;
                FPP_ADR_OVL:
                    rd_data_q <= {4'h0, ovl_en_q, ovl_sel_q};
                FPP_ADR_DLTGT:
                    rd_data_q <= dl_tgt_q;
                FPP_ADR_PECMD:
                    rd_data_q <= {6'h00, pe_erase_q, pe_prog_q};
                FPP_ADR_RESULT:
                    rd_data_q <= result_q;
                default:
                    rd_data_q <= 8'h00;
            endcase
        end
        else
            rd_data_q <= 8'h00;
    end

endmodule : fpp_guard

// [dv/fpp_flash_model.sv]
/*
 * stand-in for the flash macro: answers download and program/erase starts.
 * assumes the guard's start pulse and run levels on clk_sys.
 */
`timescale 1ns/1ns
module fpp_flash_model
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] lat,
    input wire logic dl_start_q,
    input wire logic pe_prog_q,
    input wire logic pe_erase_q,
    output logic dl_done,
    output logic pe_done
);
    // ==========================================================
    // done pulses lat+2 cycles after the download start, lat+1 after the run level rises; the bench picks prompt or slow
    logic [7:0] dl_cnt_q;
    logic [7:0] pe_cnt_q;
    logic dl_run_q;
    logic run;

    assign run = pe_prog_q | pe_erase_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dl_run_q <= 1'b0;
            dl_done <= 1'b0;
            dl_cnt_q <= 8'h00;
        end
        else
        begin
            dl_done <= dl_run_q && dl_cnt_q == lat;
            dl_cnt_q <= dl_run_q ? dl_cnt_q + 8'h01 : 8'h00;
            dl_run_q <= dl_start_q | (dl_run_q & ~dl_done);
        end
    end

    // counter past lat after the pulse, so a lingering run level cannot repeat it
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pe_done <= 1'b0;
            pe_cnt_q <= 8'h00;
        end
        else
        begin
            pe_done <= run && pe_cnt_q == lat;
            pe_cnt_q <= run ? pe_cnt_q + 8'h01 : 8'h00;
        end
    end
endmodule : fpp_flash_model

// [dv/fpp_guard_props.sv]
/*
 * assertions on the ports of the program/erase guard.
 * assumes a bind to fpp_guard; sees its ports only.
 */
`timescale 1ns/1ns
module fpp_guard_props
    import fpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire fpp_reg_req_t reg_req,
    input wire fpp_flash_req_t flash_req,
    input wire fpp_ram_req_t ram_req,
    input wire fpp_err_evt_t err_evt,
    input wire logic user_mode,
    input wire logic dl_start_q,
    input wire logic pe_prog_q,
    input wire logic pe_erase_q,
    input wire logic pe_abort_q,
    input wire logic err_flag_q,
    input wire logic ovl_hit_q,
    input wire logic ovl_rvalid_q
);
    // ==========================================================
    // shadows of key and overlay registers
    logic [7:0] key_q;
    logic [3:0] ovl_q;
    logic run;
    logic bad;
    logic hit;

    assign run = pe_prog_q | pe_erase_q;
    assign bad = (|err_evt) | (flash_req.req & ~flash_req.we);
    assign hit = flash_req.req & ~ram_req.req & user_mode & ovl_q[FPP_OVL_EN]
        & (flash_req.blk == ovl_q[2:0]);

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            key_q <= 8'h00;
            ovl_q <= 4'h0;
        end
        else if (reg_req.we)
        begin
            if (reg_req.addr == FPP_ADR_KEY)
                key_q <= reg_req.wdata;
            if (reg_req.addr == FPP_ADR_OVL)
                ovl_q <= reg_req.wdata[3:0];
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    chk_rst_clear: assert property ($fell(srst) |-> !(run | dl_start_q | err_flag_q))
        else $error("outputs not clear after reset");
    chk_dl_cause: assert property (dl_start_q |-> $past(reg_req.we)
        && $past(reg_req.addr) == FPP_ADR_CTRL && $past(reg_req.wdata[FPP_CTRL_DLREQ]))
        else $error("download started without request");
    chk_dl_key: assert property (dl_start_q |-> $past(key_q) == FPP_KEY_DL
        && !$past(ovl_q[FPP_OVL_EN])) else $error("download started while protected");
    chk_pe_key: assert property ($rose(run) |-> $past(key_q) == FPP_KEY_PE
        && !$past(ovl_q[FPP_OVL_EN]) && !$past(err_flag_q))
        else $error("operation started while protected");
    chk_err_abort: assert property (run && bad |=> pe_abort_q && err_flag_q && !run)
        else $error("error event did not abort");
    chk_abort_cause: assert property (pe_abort_q |-> $past(run) && $past(bad))
        else $error("abort without error event");
    chk_err_hold: assert property (err_flag_q |=> err_flag_q)
        else $error("error flag cleared without reset");
    chk_err_block: assert property (err_flag_q |-> !dl_start_q && !run)
        else $error("start during error protection");
    chk_ovl_hit: assert property (!$past(srst) |-> ovl_hit_q == $past(hit))
        else $error("overlay hit mismatch");
    chk_ram_rvalid: assert property (ram_req.req && !ram_req.we |=> ovl_rvalid_q)
        else $error("ram read not answered");

    cov_dl: cover property (dl_start_q);
    cov_abort: cover property (pe_abort_q);
    cov_hit: cover property (ovl_hit_q);
endmodule : fpp_guard_props

// [dv/fpp_guard_tb.sv]
/*
 * self-checking bench for the program/erase guard and overlay.
 * assumes the flash model answers each start lat+1 or lat+2 cycles later.
 */
`timescale 1ns/1ns
module fpp_guard_tb
    import fpp_pkg::*;
;
    logic clk_sys;
    logic srst;
    fpp_reg_req_t reg_req;
    fpp_flash_req_t flash_req;
    fpp_ram_req_t ram_req;
    fpp_err_evt_t err_evt;
    logic user_mode;
    logic [7:0] lat;
    logic [7:0] rd_data_q;
    logic [7:0] ovl_rdata;
    logic dl_done, pe_done, dl_start_q, pe_prog_q, pe_erase_q, pe_abort_q;
    logic err_flag_q, ovl_hit_q, ovl_rvalid_q;
    int err_total = 0;
    int total_checks = 0;

    fpp_guard fpp_guard_inst (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
        .rd_data_q(rd_data_q), .flash_req(flash_req), .ram_req(ram_req), .err_evt(err_evt),
        .user_mode(user_mode), .dl_done(dl_done), .pe_done(pe_done), .dl_start_q(dl_start_q),
        .pe_prog_q(pe_prog_q), .pe_erase_q(pe_erase_q), .pe_abort_q(pe_abort_q),
        .err_flag_q(err_flag_q), .ovl_hit_q(ovl_hit_q), .ovl_rvalid_q(ovl_rvalid_q),
        .ovl_rdata(ovl_rdata));
    fpp_flash_model fpp_flash_model_inst (.clk_sys(clk_sys), .srst(srst), .lat(lat),
        .dl_start_q(dl_start_q), .pe_prog_q(pe_prog_q), .pe_erase_q(pe_erase_q),
        .dl_done(dl_done), .pe_done(pe_done));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // shared tasks; each but chk ends 1 ns after an edge
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        reg_req.we <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string w);
        @(posedge clk_sys);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        reg_req.re <= 1'b0;
        #1;
        chk(w, e, rd_data_q);
    endtask : rd

    task automatic fl(input logic [2:0] b, input logic w, input logic e, input logic [7:0] d);
        @(posedge clk_sys);
        flash_req <= '{1'b1, w, b, 6'h05, d};
        @(posedge clk_sys);
        flash_req.req <= 1'b0;
        #1;
        chk("ovl_hit_q", {7'h0, e}, {7'h0, ovl_hit_q});
        if (e && !w)
            chk("ovl_rdata", d, ovl_rdata);
    endtask : fl

    task automatic rm(input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        ram_req <= '{1'b1, w, 6'h05, d};
        @(posedge clk_sys);
        ram_req.req <= 1'b0;
        #1;
        if (!w)
        begin
            chk("ovl_rdata", d, ovl_rdata);
            chk("ovl_rvalid_q", 8'h01, {7'h0, ovl_rvalid_q});
        end
    endtask : rm

    task automatic quiet(input int n);
        logic s;
        s = 1'b0;
        repeat (n)
        begin
            s = s | dl_start_q | pe_prog_q | pe_erase_q;
            @(posedge clk_sys);
            #1;
        end
        chk("refused start", 8'h00, {7'h0, s});
    endtask : quiet

    task automatic wait_done(input logic pe);
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clk_sys);
            #1;
            if ((pe ? pe_done : dl_done) === 1'b1)
                break;
        end
    endtask : wait_done

    task automatic rst(input int n);
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (n) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        chk("outputs", 8'h00, {4'h0, pe_prog_q, pe_erase_q, pe_abort_q, err_flag_q});
    endtask : rst

    task automatic dl();
        wr(FPP_ADR_KEY, FPP_KEY_DL);
        wr(FPP_ADR_CTRL, 8'h01);
        chk("dl_start_q", 8'h01, {7'h0, dl_start_q});
        wait_done(1'b0);
        wr(FPP_ADR_KEY, 8'h00);
        rd(FPP_ADR_CTRL, 8'h02, "ctrl");
    endtask : dl

    task automatic pe_run(input logic [7:0] c);
        wr(FPP_ADR_PECMD, c);
        chk("pe op", c, {6'h0, pe_erase_q, pe_prog_q});
        wait_done(1'b1);
        @(posedge clk_sys);
        #1;
        chk("pe op", 8'h00, {6'h0, pe_erase_q, pe_prog_q});
        rd(FPP_ADR_RESULT, FPP_RSLT_OK, "result");
    endtask : pe_run

    // ==========================================================
    // scenarios
    // reset values, unmapped
    task automatic t_reset();
        for (int a = 0; a < 8; a++)
            rd(3'(a), 8'h00, "reset value");
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00, "unmapped");
        wr(FPP_ADR_DLTGT, 8'h02);
        rd(FPP_ADR_DLTGT, 8'h02, "dltgt");
        wr(FPP_ADR_KEY, FPP_KEY_DL);
        wr(FPP_ADR_CTRL, 8'h00);
        quiet(3);
        wr(FPP_ADR_KEY, FPP_KEY_PE);
        wr(FPP_ADR_CTRL, 8'h01);
        quiet(3);
    endtask : t_reset

    task automatic t_ovl();
        logic [2:0] k;
        for (int b = 0; b < 8; b++)
        begin
            k = b[2:0];
            wr(FPP_ADR_OVL, {5'h01, k});
            rm(1'b1, {5'h06, k});
            fl(k, 1'b0, 1'b1, {5'h06, k});
            fl(k + 3'h1, 1'b0, 1'b0, 8'h00);
        end
        fl(3'h7, 1'b1, 1'b1, 8'h5c);
        rm(1'b0, 8'h5c);
        @(posedge clk_sys);
        user_mode <= 1'b0;
        fl(3'h7, 1'b0, 1'b0, 8'h00);
        @(posedge clk_sys);
        user_mode <= 1'b1;
        wr(FPP_ADR_KEY, FPP_KEY_DL);
        wr(FPP_ADR_CTRL, 8'h01);
        quiet(3);
        wr(FPP_ADR_OVL, 8'h00);
    endtask : t_ovl

    task automatic t_prog();
        wr(FPP_ADR_KEY, FPP_KEY_PE);
        wr(FPP_ADR_PECMD, 8'h01);
        quiet(3);
        rd(FPP_ADR_RESULT, FPP_RSLT_NODL, "result");
        dl();
        wr(FPP_ADR_PECMD, 8'h01);
        quiet(3);
        rd(FPP_ADR_RESULT, FPP_RSLT_KEY, "result");
        wr(FPP_ADR_OVL, 8'h08);
        wr(FPP_ADR_KEY, FPP_KEY_PE);
        wr(FPP_ADR_PECMD, 8'h02);
        quiet(3);
        rd(FPP_ADR_RESULT, FPP_RSLT_OVL, "result");
        wr(FPP_ADR_OVL, 8'h00);
        pe_run(8'h01);
        lat <= 8'h20;
        pe_run(8'h02);
        wr(FPP_ADR_PECMD, 8'h01);
        rst(4);
        dl();
        wr(FPP_ADR_KEY, FPP_KEY_PE);
        pe_run(8'h02);
        pe_run(8'h01);
        wr(FPP_ADR_PECMD, 8'h03);
        chk("pe both", 8'h01, {6'h0, pe_erase_q, pe_prog_q});
        wait_done(1'b1);
        wr(FPP_ADR_KEY, 8'h00);
    endtask : t_prog

    task automatic t_err();
        for (int k = 0; k < 5; k++)
        begin
            dl();
            wr(FPP_ADR_KEY, FPP_KEY_PE);
            wr(FPP_ADR_PECMD, 8'h01);
            @(posedge clk_sys);
            if (k < 4)
                err_evt <= fpp_err_evt_t'(4'h1 << k);
            else
                flash_req <= '{1'b1, 1'b0, 3'h0, 6'h00, 8'h00};
            @(posedge clk_sys);
            err_evt <= '0;
            flash_req.req <= 1'b0;
            #1;
            chk("abort", 8'h03, {6'h0, pe_abort_q, err_flag_q});
            rd(FPP_ADR_RESULT, FPP_RSLT_ABORT, "result");
            wr(FPP_ADR_KEY, FPP_KEY_DL);
            wr(FPP_ADR_CTRL, 8'h81);
            quiet(3);
            chk("err_flag_q", 8'h01, {7'h0, err_flag_q});
            wr(FPP_ADR_KEY, FPP_KEY_PE);
            wr(FPP_ADR_PECMD, 8'h01);
            rd(FPP_ADR_RESULT, FPP_RSLT_ERRP, "result");
            rst(FPP_RST_HOLD_CYC);
        end
    endtask : t_err

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        srst = 1'b1;
        reg_req = '0;
        flash_req = '0;
        ram_req = '0;
        err_evt = '0;
        user_mode = 1'b1;
        lat = 8'h01;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_ovl();
        t_prog();
        t_err();
        finish_test();
    end

    // five long reset holds dominate the run time
    initial
    begin
        repeat (70000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end
endmodule : fpp_guard_tb

bind fpp_guard fpp_guard_props fpp_guard_props_inst (.clk_sys(clk_sys), .srst(srst),
    .reg_req(reg_req), .flash_req(flash_req), .ram_req(ram_req), .err_evt(err_evt),
    .user_mode(user_mode), .dl_start_q(dl_start_q), .pe_prog_q(pe_prog_q),
    .pe_erase_q(pe_erase_q), .pe_abort_q(pe_abort_q), .err_flag_q(err_flag_q),
    .ovl_hit_q(ovl_hit_q), .ovl_rvalid_q(ovl_rvalid_q));
